// *** sdcu_debug_unit.sv ***
// Overview of operation
// [R1] Select codes 0-3 load the write nibble into data holding word nibbles 0-3.
// [R2] Select codes 4-7 load the write nibble into address register nibbles 0-3.
// [R3] Select code 8 loads the command code and starts that command.
// [R4] Select code 9 loads the link wire mode register.
// [R5] Select codes 10-15 change nothing; command 1100 does nothing.
// [R6] Command 0 writes the data word to CPU port address[3:0], CPU may run.
// [R7] Command 1 programs data low byte into flash address[11:0], CPU halted.
// [R8] Command 2 copies CPU port address[3:0] into the data word, CPU may run.
// [R9] Command 3 reads flash byte address[11:0] into data bits 7:0, halted.
// [R10] Command 4 copies the accumulator into the data word, halted.
// [R11] Command 5 reads flash byte at program counter into data bits 7:0, halted.
// [R12] Command 6 copies the program counter into the data word, halted.
// [R13] Command 7 halts the CPU; command 8 restarts it when halted.
// [R14] Command 9 when halted runs exactly one CPU cycle, stays halted.
// [R15] Command 10 when halted clears the program counter.
// [R16] Command 11 when halted resets modules, flash controller, registers D E F.
// [R17] Command 13 when halted erases the 64-byte page at address[11:6].
// [R18] Command 14 when halted erases the whole selected flash partition.
// [R19] Command 15 when halted selects auxiliary partition; next halt returns to main partition.
// [R20] CPU wins simultaneous port access; the serial access waits.
// [R21] Host should halt, snapshot, restore values, then restart.
// [R22] Flash byte writes happen only with the flash write permit set.
// [R23] Mode 0000 gives separate data lines, 0001 a shared three-wire line.
`timescale 1ns/10ps
`default_nettype none

module sdcu_debug_unit (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Host side, asynchronous to mclk
  input wire logic linkClk,
  input wire logic hostWrite,
  input wire logic [3:0] internalSelectCode,
  input wire logic [sdcu_pkg::NIB_W-1:0] writeNibble,
  // Register view
  output logic [sdcu_pkg::WORD_W-1:0] dataHoldingWord,
  output logic [3:0] linkWireMode,
  output logic sharedDataLine,
  output logic cmdBusy,
  // CPU control
  input wire logic [sdcu_pkg::WORD_W-1:0] cpuAcc,
  input wire logic [sdcu_pkg::WORD_W-1:0] cpuPc,
  output logic cpuHalt,
  output logic cpuStep,
  output logic pcClear,
  output logic moduleReset,
  // CPU port access
  input wire logic cpuPortBusy,
  input wire logic [sdcu_pkg::WORD_W-1:0] portRdData,
  output logic [sdcu_pkg::PORT_W-1:0] portAddr,
  output logic [sdcu_pkg::WORD_W-1:0] portWrData,
  output logic portWe,
  output logic portRe,
  // Flash controller
  input wire logic flashWritePermit,
  input wire logic flashDone,
  input wire logic [sdcu_pkg::BYTE_W-1:0] flashRdData,
  output logic [sdcu_pkg::FADDR_W-1:0] flashAddr,
  output logic [sdcu_pkg::BYTE_W-1:0] flashWrData,
  output logic flashWe,
  output logic flashRe,
  output logic flashPageErase,
  output logic flashPartErase,
  output logic auxPartitionSel
);
  import sdcu_pkg::*;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic [WORD_W-1:0] setNibble(input logic [WORD_W-1:0] w, input logic [1:0] idx,
                                                 input logic [NIB_W-1:0] n);
    logic [WORD_W-1:0] r;
    r = w;
    r[idx*NIB_W +: NIB_W] = n;
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Host input synchronisation
  // ----------------------------------------------------------------
  logic [SYNC_W-1:0] syncVec;
  logic linkS, wrS, linkPrev_ff;
  logic [3:0] selS;
  logic [NIB_W-1:0] nibS;

  sdcu_sync #(.W(SYNC_W)) u_sync (
    .mclk(mclk),
    .rst(rst),
    .asyncIn({linkClk, hostWrite, internalSelectCode, writeNibble}),
    .syncOut(syncVec)
  );

  assign {linkS, wrS, selS, nibS} = syncVec;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      linkPrev_ff <= 1'b0;
    end else begin
      linkPrev_ff <= linkS;
    end
  end

  // ----------------------------------------------------------------
  // Nibble write decode
  // ----------------------------------------------------------------
  sdcu_state_t state_ff, nxt_state;
  logic isIdle, nibTake, selDhw, selPfa, selCmd, selMode;

  // Writes during a running command are dropped so the sequencer sees stable operands
  assign isIdle = (state_ff == ST_IDLE);
  assign nibTake = linkS & ~linkPrev_ff & wrS & isIdle;
  assign selDhw = nibTake && (selS <= SEL_DHW3);
  assign selPfa = nibTake && (selS >= SEL_PFA0) && (selS <= SEL_PFA3);
  assign selCmd = nibTake && (selS == SEL_CMD);
  assign selMode = nibTake && (selS == SEL_MODE);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [WORD_W-1:0] dhw_ff, nxt_dhw, pfa_ff;
  logic [3:0] cmd_ff, mode_ff;
  logic go_ff, halt_ff, nxt_halt, aux_ff, nxt_aux, flashRd_ff, nxt_flashRd;
  logic nxt_step, nxt_pcClr, nxt_modRst, nxt_portWe, nxt_portRe;
  logic nxt_flashWe, nxt_flashRe, nxt_pageErase, nxt_partErase;
  logic [FADDR_W-1:0] nxt_flashAddr;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pfa_ff <= RST_WORD;
      cmd_ff <= RST_NIB;
      mode_ff <= RST_NIB;
      go_ff <= 1'b0;
    end else begin
      if (selPfa) pfa_ff <= setNibble(pfa_ff, selS[1:0], nibS); // R2
      if (selCmd) cmd_ff <= nibS; // R3
      if (selMode) mode_ff <= nibS; // R4
      go_ff <= selCmd; // R3
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_ff <= ST_IDLE;
      dhw_ff <= RST_WORD;
      halt_ff <= 1'b0;
      aux_ff <= 1'b0;
      flashRd_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      dhw_ff <= nxt_dhw;
      halt_ff <= nxt_halt;
      aux_ff <= nxt_aux;
      flashRd_ff <= nxt_flashRd;
    end
  end

  // ----------------------------------------------------------------
  // Command sequencer
  // ----------------------------------------------------------------
  logic [FADDR_W-1:0] pageBase;
  assign pageBase = {pfa_ff[FADDR_W-1:PAGE_LSB], PAGE_PAD};

  always_comb begin
    nxt_state = state_ff;
    nxt_dhw = dhw_ff;
    nxt_halt = halt_ff;
    nxt_aux = aux_ff;
    nxt_flashRd = flashRd_ff;
    nxt_step = 1'b0;
    nxt_pcClr = 1'b0;
    nxt_modRst = 1'b0;
    nxt_portWe = 1'b0;
    nxt_portRe = 1'b0;
    nxt_flashWe = 1'b0;
    nxt_flashRe = 1'b0;
    nxt_pageErase = 1'b0;
    nxt_partErase = 1'b0;
    nxt_flashAddr = flashAddr;
    if (selDhw) nxt_dhw = setNibble(dhw_ff, selS[1:0], nibS); // R1
    case (state_ff)
      ST_IDLE: begin
        if (go_ff) begin
          // Halt-only commands given while running are ignored
          case (cmd_ff)
            CMD_PORT_WR: nxt_state = ST_PORT; // R6
            CMD_PORT_RD: nxt_state = ST_PORT; // R8
            CMD_HALT: begin
              nxt_halt = 1'b1; // R13
              nxt_aux = 1'b0; // R19
            end
            default: begin
              if (halt_ff) begin
                case (cmd_ff)
                  CMD_FLASH_WR: begin
                    if (flashWritePermit) begin
                      nxt_flashWe = 1'b1; // R7 R22
                      nxt_flashAddr = pfa_ff[FADDR_W-1:0];
                      nxt_flashRd = 1'b0;
                      nxt_state = ST_FLASH;
                    end
                  end
                  CMD_FLASH_RD: begin
                    nxt_flashRe = 1'b1; // R9
                    nxt_flashAddr = pfa_ff[FADDR_W-1:0];
                    nxt_flashRd = 1'b1;
                    nxt_state = ST_FLASH;
                  end
                  CMD_PCMEM_RD: begin
                    nxt_flashRe = 1'b1; // R11
                    nxt_flashAddr = cpuPc[FADDR_W-1:0];
                    nxt_flashRd = 1'b1;
                    nxt_state = ST_FLASH;
                  end
                  CMD_ACC_RD: nxt_dhw = cpuAcc; // R10
                  CMD_PC_RD: nxt_dhw = cpuPc; // R12
                  CMD_START: nxt_halt = 1'b0; // R13
                  CMD_STEP: nxt_step = 1'b1; // R14
                  CMD_PC_CLR: nxt_pcClr = 1'b1; // R15
                  CMD_MOD_RST: nxt_modRst = 1'b1; // R16
                  CMD_PAGE_ERASE: begin
                    nxt_pageErase = 1'b1; // R17
                    nxt_flashAddr = pageBase;
                    nxt_flashRd = 1'b0;
                    nxt_state = ST_FLASH;
                  end
                  CMD_PART_ERASE: begin
                    nxt_partErase = 1'b1; // R18
                    nxt_flashRd = 1'b0;
                    nxt_state = ST_FLASH;
                  end
                  CMD_AUX_SEL: nxt_aux = 1'b1; // R19
                  default: nxt_state = ST_IDLE; // R5
                endcase
              end
            end
          endcase
        end
      end
      ST_PORT: begin
        // The CPU owns the ports whenever it is using them
        if (!cpuPortBusy) begin
          if (cmd_ff == CMD_PORT_WR) begin
            nxt_portWe = 1'b1; // R6 R20
            nxt_state = ST_IDLE;
          end else begin
            nxt_portRe = 1'b1; // R8 R20
            nxt_state = ST_PORT_CAPT;
          end
        end
      end
      ST_PORT_CAPT: begin
        nxt_dhw = portRdData; // R8
        nxt_state = ST_IDLE;
      end
      ST_FLASH: begin
        if (flashDone) begin
          if (flashRd_ff) begin
            nxt_dhw = {dhw_ff[WORD_W-1:BYTE_W], flashRdData}; // R9 R11
          end
          nxt_state = ST_IDLE;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // Output flops
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cpuStep <= 1'b0;
      pcClear <= 1'b0;
      moduleReset <= 1'b0;
      portWe <= 1'b0;
      portRe <= 1'b0;
      flashWe <= 1'b0;
      flashRe <= 1'b0;
      flashPageErase <= 1'b0;
      flashPartErase <= 1'b0;
      flashAddr <= RST_FADDR;
      flashWrData <= RST_BYTE;
      portAddr <= RST_NIB;
      portWrData <= RST_WORD;
    end else begin
      cpuStep <= nxt_step;
      pcClear <= nxt_pcClr;
      moduleReset <= nxt_modRst;
      portWe <= nxt_portWe;
      portRe <= nxt_portRe;
      flashWe <= nxt_flashWe;
      flashRe <= nxt_flashRe;
      flashPageErase <= nxt_pageErase;
      flashPartErase <= nxt_partErase;
      flashAddr <= nxt_flashAddr;
      flashWrData <= dhw_ff[BYTE_W-1:0]; // R7
      portAddr <= pfa_ff[PORT_W-1:0];
      portWrData <= dhw_ff; // R6
    end
  end

  assign dataHoldingWord = dhw_ff;
  assign linkWireMode = mode_ff;
  assign sharedDataLine = (mode_ff == MODE_THREE_WIRE); // R23
  assign cmdBusy = ~isIdle | go_ff;
  assign cpuHalt = halt_ff;
  assign auxPartitionSel = aux_ff;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  property p_dhw_nibble;
    (selDhw && state_ff == ST_IDLE && !go_ff) |=> (dhw_ff[$past(selS[1:0])*NIB_W +: NIB_W] == $past(nibS));
  endproperty
  a_dhw_nibble: assert property (p_dhw_nibble) else $error("data word nibble not loaded"); // R1
  property p_pfa_nibble;
    selPfa |=> (pfa_ff[$past(selS[1:0])*NIB_W +: NIB_W] == $past(nibS));
  endproperty
  a_pfa_nibble: assert property (p_pfa_nibble) else $error("address nibble not loaded"); // R2
  property p_cmd_load;
    selCmd |=> (cmd_ff == $past(nibS)) && go_ff ##1 !go_ff;
  endproperty
  a_cmd_load: assert property (p_cmd_load) else $error("command not loaded or started"); // R3
  property p_mode_load;
    selMode |=> (linkWireMode == $past(nibS)) && (sharedDataLine == ($past(nibS) == MODE_THREE_WIRE));
  endproperty
  a_mode_load: assert property (p_mode_load) else $error("mode not loaded"); // R4
  property p_unused_sel;
    (nibTake && selS > SEL_MODE) |=> $stable(pfa_ff) && $stable(cmd_ff) && $stable(mode_ff);
  endproperty
  a_unused_sel: assert property (p_unused_sel) else $error("unused select changed a register"); // R5
  property p_halt;
    (go_ff && isIdle && cmd_ff == CMD_HALT) |=> cpuHalt && !auxPartitionSel;
  endproperty
  a_halt: assert property (p_halt) else $error("halt did not halt or keep main partition"); // R13 R19
  property p_step;
    cpuStep |-> cpuHalt ##1 (!cpuStep && cpuHalt);
  endproperty
  a_step: assert property (p_step) else $error("single step not one cycle while halted"); // R14
  property p_flash_permit;
    flashWe |-> $past(flashWritePermit) && cpuHalt && (flashWrData == dataHoldingWord[BYTE_W-1:0]);
  endproperty
  a_flash_permit: assert property (p_flash_permit) else $error("flash write without permit or halt"); // R7 R22
  property p_port_prio;
    (state_ff == ST_PORT && cpuPortBusy) |=> !portWe && !portRe;
  endproperty
  a_port_prio: assert property (p_port_prio) else $error("serial port access beat the CPU"); // R20
  property p_page_addr;
    flashPageErase |-> (flashAddr[PAGE_LSB-1:0] == PAGE_PAD) && cpuHalt;
  endproperty
  a_page_addr: assert property (p_page_addr) else $error("page erase address not page aligned"); // R17

  c_port_read: cover property (@(posedge mclk) disable iff (rst) portRe && (state_ff == ST_PORT_CAPT));
  c_flash_wr: cover property (@(posedge mclk) disable iff (rst) flashWe ##[1:20] flashDone);
  c_step: cover property (@(posedge mclk) disable iff (rst) cpuStep);
  c_aux_back: cover property (@(posedge mclk) disable iff (rst) auxPartitionSel ##[1:1000] !auxPartitionSel);

endmodule // sdcu_debug_unit

`default_nettype wire

// *** sdcu_debug_unit_tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none

module sdcu_debug_unit_tb_top;
  import sdcu_pkg::*;

  typedef struct packed {
    logic [3:0] sel;
    logic [3:0] nib;
    logic [15:0] word;
    logic [3:0] mode;
  } sdcu_row_t;

  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic linkClk, hostWrite, sharedDataLine, cmdBusy, cpuHalt, cpuStep, pcClear, moduleReset;
  logic portWe, portRe, flashWe, flashRe, flashPageErase, flashPartErase, auxPartitionSel;
  logic [3:0] internalSelectCode, writeNibble, linkWireMode, portAddr;
  logic [15:0] dataHoldingWord, portWrData;
  logic [15:0] cpuAcc = 16'h0000;
  logic [15:0] cpuPc = 16'h0000;
  logic [15:0] portRdData = 16'h0000;
  logic cpuPortBusy = 1'b0;
  logic flashWritePermit = 1'b0;
  logic flashDone = 1'b0;
  logic [7:0] flashRdData = 8'h00;
  logic [7:0] flashWrData;
  logic [11:0] flashAddr;
  logic [8:0] pulses;
  int pulseCnt [9];
  int error_cnt = 0;
  int samples_checked = 0;
  sdcu_row_t rows [8];

  initial begin
    forever #50 mclk = ~mclk;
  end

  sdcu_host_model sdcu_host_model_inst (
    .linkClk(linkClk), .hostWrite(hostWrite),
    .internalSelectCode(internalSelectCode), .writeNibble(writeNibble)
  );

  sdcu_debug_unit sdcu_debug_unit_inst (
    .mclk(mclk), .rst(rst), .linkClk(linkClk), .hostWrite(hostWrite),
    .internalSelectCode(internalSelectCode), .writeNibble(writeNibble),
    .dataHoldingWord(dataHoldingWord), .linkWireMode(linkWireMode),
    .sharedDataLine(sharedDataLine), .cmdBusy(cmdBusy), .cpuAcc(cpuAcc), .cpuPc(cpuPc),
    .cpuHalt(cpuHalt), .cpuStep(cpuStep), .pcClear(pcClear), .moduleReset(moduleReset),
    .cpuPortBusy(cpuPortBusy), .portRdData(portRdData), .portAddr(portAddr),
    .portWrData(portWrData), .portWe(portWe), .portRe(portRe),
    .flashWritePermit(flashWritePermit), .flashDone(flashDone), .flashRdData(flashRdData),
    .flashAddr(flashAddr), .flashWrData(flashWrData), .flashWe(flashWe), .flashRe(flashRe),
    .flashPageErase(flashPageErase), .flashPartErase(flashPartErase),
    .auxPartitionSel(auxPartitionSel)
  );

  // ----------------------------------------------------------------
  // Flash controller stand-in and pulse counters
  // ----------------------------------------------------------------
  always @(posedge mclk) flashDone <= flashWe | flashRe | flashPageErase | flashPartErase;

  // Index: 8 step, 7 pcClear, 6 modRst, 5 portWe, 4 portRe, 3 flashWe, 2 flashRe, 1 page, 0 part
  assign pulses = {cpuStep, pcClear, moduleReset, portWe, portRe, flashWe, flashRe, flashPageErase,
                   flashPartErase};
  always @(posedge mclk) begin
    for (int i = 0; i < 9; i++) begin
      pulseCnt[i] <= pulseCnt[i] + int'(pulses[i] === 1'b1);
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic results();
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", name, exp, got);
      error_cnt++;
    end
  endtask

  task automatic nib(input logic [3:0] sel, input logic [3:0] val);
    sdcu_host_model_inst.sendNibble(sel, val);
    repeat (2) @(posedge mclk);
    #1;
  endtask

  task automatic waitIdle();
    int n;
    for (n = 0; n < 60 && cmdBusy !== 1'b0; n++) begin
      @(posedge mclk);
      #1;
    end
    if (cmdBusy !== 1'b0) begin
      chk("cmdBusy wait", 16'h0000, 16'h0001);
      results();
    end
    // Busy drops no earlier than the edge that launches the last pulse; let the counters see it
    @(posedge mclk);
    #1;
  endtask

  task automatic cmd(input logic [3:0] c);
    nib(SEL_CMD, c);
    waitIdle();
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rows[0] = '{SEL_DHW0, 4'h1, 16'h0001, 4'h0};
    rows[1] = '{4'h1, 4'h2, 16'h0021, 4'h0};
    rows[2] = '{4'h2, 4'h3, 16'h0321, 4'h0};
    rows[3] = '{SEL_DHW3, 4'h4, 16'h4321, 4'h0};
    rows[4] = '{SEL_MODE, MODE_THREE_WIRE, 16'h4321, 4'h1};
    rows[5] = '{4'hA, 4'hF, 16'h4321, 4'h1};
    rows[6] = '{4'hF, 4'h5, 16'h4321, 4'h1};
    rows[7] = '{SEL_MODE, MODE_FOUR_WIRE, 16'h4321, 4'h0};
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    #1;
    chk("rst word", 16'h0000, dataHoldingWord);
    chk("rst halt", 16'h0000, {15'h0000, cpuHalt});
    chk("rst aux", 16'h0000, {15'h0000, auxPartitionSel});
    foreach (rows[i]) begin
      nib(rows[i].sel, rows[i].nib);
      chk("word", rows[i].word, dataHoldingWord);
      chk("mode", {12'h000, rows[i].mode}, {12'h000, linkWireMode});
      chk("shared", {15'h0000, rows[i].mode == 4'h1}, {15'h0000, sharedDataLine});
    end
    @(posedge mclk);
    cpuAcc <= 16'h5A5A;
    cpuPc <= 16'h0123;
    portRdData <= 16'h1234;
    flashRdData <= 8'h77;
    cmd(CMD_ACC_RD);
    chk("acc while running", 16'h4321, dataHoldingWord);
    cmd(CMD_STEP);
    chk("step while running", 16'h0000, 16'(pulseCnt[8]));
    nib(4'h4, 4'h5);
    nib(4'h5, 4'hC);
    nib(4'h6, 4'hF);
    nib(SEL_PFA3, 4'h0);
    nib(SEL_DHW0, 4'hD);
    nib(4'h1, 4'hC);
    nib(4'h2, 4'hB);
    nib(SEL_DHW3, 4'hA);
    chk("word", 16'hABCD, dataHoldingWord);
    @(posedge mclk);
    cpuPortBusy <= 1'b1;
    nib(SEL_CMD, CMD_PORT_WR);
    repeat (10) @(posedge mclk);
    chk("portWe stalled", 16'h0000, 16'(pulseCnt[5]));
    nib(SEL_DHW0, 4'h0);
    chk("busy write dropped", 16'hABCD, dataHoldingWord);
    @(posedge mclk);
    cpuPortBusy <= 1'b0;
    waitIdle();
    chk("portWe", 16'h0001, 16'(pulseCnt[5]));
    chk("portWrData", 16'hABCD, portWrData);
    chk("portAddr", 16'h0005, {12'h000, portAddr});
    cmd(CMD_PORT_RD);
    chk("port read", 16'h1234, dataHoldingWord);
    chk("portRe", 16'h0001, 16'(pulseCnt[4]));
    // Snapshot reads below are made with the CPU halted
    cmd(CMD_HALT);
    chk("halt", 16'h0001, {15'h0000, cpuHalt});
    cmd(CMD_ACC_RD);
    chk("acc", 16'h5A5A, dataHoldingWord);
    cmd(CMD_PC_RD);
    chk("pc", 16'h0123, dataHoldingWord);
    cmd(CMD_PCMEM_RD);
    chk("pc byte", 16'h0177, dataHoldingWord);
    cmd(CMD_STEP);
    cmd(CMD_PC_CLR);
    cmd(CMD_MOD_RST);
    chk("step", 16'h0001, 16'(pulseCnt[8]));
    chk("halt after step", 16'h0001, {15'h0000, cpuHalt});
    chk("pcClear", 16'h0001, 16'(pulseCnt[7]));
    chk("moduleReset", 16'h0001, 16'(pulseCnt[6]));
    cmd(CMD_NOP);
    chk("nop word", 16'h0177, dataHoldingWord);
    chk("nop pulses", 16'h0004, 16'(pulseCnt[8] + pulseCnt[7] + pulseCnt[6] + pulseCnt[2]));
    cmd(CMD_FLASH_WR);
    chk("write no permit", 16'h0000, 16'(pulseCnt[3]));
    @(posedge mclk);
    flashWritePermit <= 1'b1;
    flashRdData <= 8'h3C;
    cmd(CMD_FLASH_WR);
    chk("flashWe", 16'h0001, 16'(pulseCnt[3]));
    chk("flashWrData", 16'h0077, {8'h00, flashWrData});
    chk("flashAddr wr", 16'h0FC5, {4'h0, flashAddr});
    cmd(CMD_FLASH_RD);
    chk("flash read", 16'h013C, dataHoldingWord);
    cmd(CMD_PAGE_ERASE);
    chk("page erase", 16'h0001, 16'(pulseCnt[1]));
    chk("page addr", 16'h0FC0, {4'h0, flashAddr});
    cmd(CMD_AUX_SEL);
    chk("aux", 16'h0001, {15'h0000, auxPartitionSel});
    cmd(CMD_PART_ERASE);
    chk("part erase", 16'h0001, 16'(pulseCnt[0]));
    cmd(CMD_HALT);
    chk("aux cleared", 16'h0000, {15'h0000, auxPartitionSel});
    cmd(CMD_START);
    chk("start", 16'h0000, {15'h0000, cpuHalt});
    cmd(CMD_HALT);
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    #1;
    chk("rerst word", 16'h0000, dataHoldingWord);
    chk("rerst halt", 16'h0000, {15'h0000, cpuHalt});
    results();
  end
endmodule // sdcu_debug_unit_tb_top

`default_nettype wire

// *** sdcu_host_model.sv ***
`timescale 1ns/10ps
`default_nettype none

module sdcu_host_model (
  // Link pins toward the debug unit
  output logic linkClk,
  output logic hostWrite,
  output logic [3:0] internalSelectCode,
  output logic [3:0] writeNibble
);
  initial begin
    linkClk = 1'b0;
    hostWrite = 1'b0;
    internalSelectCode = 4'h0;
    writeNibble = 4'h0;
  end

  // ----------------------------------------------------------------
  // One nibble frame
  // ----------------------------------------------------------------
  // Link clock only moves inside a frame; once hold time is over the lines
  // show the inverse, so a design that samples late cannot see the old value
  task automatic sendNibble(input logic [3:0] sel, input logic [3:0] nib);
    internalSelectCode = sel;
    writeNibble = nib;
    hostWrite = 1'b1;
    #400;
    linkClk = 1'b1;
    #400;
    linkClk = 1'b0;
    hostWrite = 1'b0;
    internalSelectCode = ~sel;
    writeNibble = ~nib;
  endtask
endmodule // sdcu_host_model

`default_nettype wire

// *** sdcu_pkg.sv ***
package sdcu_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int WORD_W = 16;
  localparam int NIB_W = 4;
  localparam int BYTE_W = 8;
  localparam int FADDR_W = 12;
  localparam int PORT_W = 4;
  localparam int PAGE_LSB = 6;
  localparam int SYNC_W = 10;

  // ----------------------------------------------------------------
  // Select codes for nibble writes
  // ----------------------------------------------------------------
  localparam logic [3:0] SEL_DHW0 = 4'h0;
  localparam logic [3:0] SEL_DHW3 = 4'h3;
  localparam logic [3:0] SEL_PFA0 = 4'h4;
  localparam logic [3:0] SEL_PFA3 = 4'h7;
  localparam logic [3:0] SEL_CMD = 4'h8;
  localparam logic [3:0] SEL_MODE = 4'h9;

  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [3:0] CMD_PORT_WR = 4'h0;
  localparam logic [3:0] CMD_FLASH_WR = 4'h1;
  localparam logic [3:0] CMD_PORT_RD = 4'h2;
  localparam logic [3:0] CMD_FLASH_RD = 4'h3;
  localparam logic [3:0] CMD_ACC_RD = 4'h4;
  localparam logic [3:0] CMD_PCMEM_RD = 4'h5;
  localparam logic [3:0] CMD_PC_RD = 4'h6;
  localparam logic [3:0] CMD_HALT = 4'h7;
  localparam logic [3:0] CMD_START = 4'h8;
  localparam logic [3:0] CMD_STEP = 4'h9;
  localparam logic [3:0] CMD_PC_CLR = 4'hA;
  localparam logic [3:0] CMD_MOD_RST = 4'hB;
  localparam logic [3:0] CMD_NOP = 4'hC;
  localparam logic [3:0] CMD_PAGE_ERASE = 4'hD;
  localparam logic [3:0] CMD_PART_ERASE = 4'hE;
  localparam logic [3:0] CMD_AUX_SEL = 4'hF;

  // ----------------------------------------------------------------
  // Link wire modes and reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] MODE_FOUR_WIRE = 4'h0;
  localparam logic [3:0] MODE_THREE_WIRE = 4'h1;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [3:0] RST_NIB = 4'h0;
  localparam logic [11:0] RST_FADDR = 12'h000;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [5:0] PAGE_PAD = 6'h00;

  // ----------------------------------------------------------------
  // Command sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_PORT = 3'b001,
    ST_PORT_CAPT = 3'b010,
    ST_FLASH = 3'b011
  } sdcu_state_t;

endpackage

// *** sdcu_sync.sv ***
`timescale 1ns/10ps
`default_nettype none

module sdcu_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Data
  input wire logic [W-1:0] asyncIn,
  output logic [W-1:0] syncOut
);

  logic [W-1:0] meta_ff;

  // Meta stage is read only by the second stage
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      meta_ff <= '0;
      syncOut <= '0;
    end else begin
      meta_ff <= asyncIn;
      syncOut <= meta_ff;
    end
  end

endmodule // sdcu_sync

`default_nettype wire
